// file: src/data_move_defs.svh
// constants for the data-move instruction unit
`ifndef DATA_MOVE_DEFS_SVH
`define DATA_MOVE_DEFS_SVH

// instruction word layout
`define INSTR_WIDTH        14
`define CLASS_MSB          13
`define CLASS_LSB          11
`define COPY_DEST_BIT      10
`define COPY_FILE_MSB      6
`define INDIR_SEL_BIT      7
`define INDIR_MODE_MSB     1
`define REL_SEL_BIT        6
`define REL_K_MSB          5
`define BANK_K_MSB         3
`define LATCH_K_MSB        6
`define WORK_K_MSB         7

// class codes
`define CLASS_NOP          3'h0
`define CLASS_COPY         3'h1
`define CLASS_INDIR        3'h2
`define CLASS_REL          3'h3
`define CLASS_BANK         3'h4
`define CLASS_LATCH        3'h5
`define CLASS_WORK         3'h6

// file addresses with no storage, redirected through the pointers
`define INDIRECT0_ADDR     7'h00
`define INDIRECT1_ADDR     7'h01

// reset values
`define WORK_RESET         8'h00
`define BANK_RESET         5'h00
`define LATCH_RESET        7'h00
`define POINTER_RESET      16'h0000

`endif

// file: src/data_move_pkg.sv
// types for the data-move instruction unit
package data_move_pkg;
   typedef enum logic [1:0] {
      mode_pre_inc,
      mode_pre_dec,
      mode_post_inc,
      mode_post_dec
   } pointer_update_mode_t;

   typedef enum {
      st_idle,
      st_read,
      st_capture,
      st_write
   } exec_state_t;
endpackage

// file: src/pointer_address_unit.sv
// effective address and updated pointer for indirect moves
`timescale 1ns/1ps
`default_nettype none
module pointer_address_unit
   import data_move_pkg::*;
#(
   parameter int PTR_WIDTH = 16
) (
   input  wire logic [PTR_WIDTH-1:0]   pointer,
   input  wire logic [1:0]             mode,
   input  wire logic                   relative,
   input  wire logic [5:0]             offset,
   output logic      [PTR_WIDTH-1:0]   effective_addr,
   output logic      [PTR_WIDTH-1:0]   next_pointer
);
   initial begin
      if (PTR_WIDTH < 7)
         $error("pointer_address_unit: pointer narrower than offset");
   end

   // plain modulo arithmetic gives the wrap at both ends
   wire logic [PTR_WIDTH-1:0] plus_one   = pointer + PTR_WIDTH'(1);
   wire logic [PTR_WIDTH-1:0] minus_one  = pointer - PTR_WIDTH'(1);
   wire logic [PTR_WIDTH-1:0] offset_ext = {{(PTR_WIDTH-6){offset[5]}}, offset};
   wire logic [PTR_WIDTH-1:0] plus_k     = pointer + offset_ext;
   wire logic                 is_inc     = (mode == 2'(mode_pre_inc)) || (mode == 2'(mode_post_inc));
   wire logic                 is_pre     = (mode == 2'(mode_pre_inc)) || (mode == 2'(mode_pre_dec));
   wire logic [PTR_WIDTH-1:0] stepped    = is_inc ? plus_one : minus_one;

   // pre modes use the stepped value, post modes the old one
   assign effective_addr = relative ? plus_k : (is_pre ? stepped : pointer);
   // relative form leaves the pointer alone
   assign next_pointer   = relative ? pointer : stepped;
endmodule // pointer_address_unit
`default_nettype wire

// file: src/data_move_instruction_unit.sv
// execution unit for the data-move instructions
`timescale 1ns/1ps
`default_nettype none
`include "data_move_defs.svh"
module data_move_instruction_unit
   import data_move_pkg::*;
#(
   parameter int PTR_WIDTH = 16
) (
   input  wire logic                     mclk,
   input  wire logic                     reset,
   input  wire logic                     instr_valid,
   input  wire logic [`INSTR_WIDTH-1:0]  instr_word,
   input  wire logic [7:0]               mem_rdata,
   output logic                          busy,
   output logic                          done,
   output logic      [PTR_WIDTH-1:0]     mem_addr,
   output logic                          mem_rd_en,
   output logic                          mem_wr_en,
   output logic      [7:0]               mem_wdata,
   output logic      [7:0]               working_reg,
   output logic                          zero_flag,
   output logic      [4:0]               bank_select_register,
   output logic      [6:0]               program_counter_high_latch,
   output logic      [PTR_WIDTH-1:0]     pointer_register0,
   output logic      [PTR_WIDTH-1:0]     pointer_register1
);
   initial begin
      if (PTR_WIDTH != 16)
         $error("data_move_instruction_unit: pointers must be 16 bits wide");
   end

   exec_state_t state;
   logic        dest_file;

   // decode of the incoming word
   wire logic [2:0] op_class  = instr_word[`CLASS_MSB:`CLASS_LSB];
   wire logic       take      = instr_valid && !busy;
   wire logic       is_copy   = take && (op_class == `CLASS_COPY);
   wire logic       is_indir  = take && (op_class == `CLASS_INDIR);
   wire logic       is_rel    = take && (op_class == `CLASS_REL);
   wire logic       is_bank   = take && (op_class == `CLASS_BANK);
   wire logic       is_latch  = take && (op_class == `CLASS_LATCH);
   wire logic       is_work   = take && (op_class == `CLASS_WORK);
   wire logic       is_lit    = is_bank || is_latch || is_work;

   wire logic [6:0] file_addr = instr_word[`COPY_FILE_MSB:0];
   wire logic       copy_dest = instr_word[`COPY_DEST_BIT];
   wire logic       ptr_sel   = is_rel ? instr_word[`REL_SEL_BIT] : instr_word[`INDIR_SEL_BIT];
   wire logic [1:0] mode      = instr_word[`INDIR_MODE_MSB:0];
   wire logic [5:0] rel_k     = instr_word[`REL_K_MSB:0];

   // literal fields; bits above each field are assumed zero and dropped
   wire logic [4:0] bank_k    = {1'b0, instr_word[`BANK_K_MSB:0]};
   wire logic [6:0] latch_k   = instr_word[`LATCH_K_MSB:0];
   wire logic [7:0] work_k    = instr_word[`WORK_K_MSB:0];

   // indirect file addresses map onto the pointers, nothing is stored
   wire logic       copy_via0 = (file_addr == `INDIRECT0_ADDR);
   wire logic       copy_via1 = (file_addr == `INDIRECT1_ADDR);
   wire logic [PTR_WIDTH-1:0] direct_addr =
      PTR_WIDTH'({bank_select_register, file_addr});
   wire logic [PTR_WIDTH-1:0] copy_addr =
      copy_via0 ? pointer_register0 :
      copy_via1 ? pointer_register1 : direct_addr;

   wire logic [PTR_WIDTH-1:0] sel_pointer = ptr_sel ? pointer_register1 : pointer_register0;
   wire logic [PTR_WIDTH-1:0] eff_addr;
   wire logic [PTR_WIDTH-1:0] next_ptr;

   pointer_address_unit #(
      .PTR_WIDTH      (PTR_WIDTH)
   ) u_addr (
      .pointer        (sel_pointer),
      .mode           (mode),
      .relative       (is_rel),
      .offset         (rel_k),
      .effective_addr (eff_addr),
      .next_pointer   (next_ptr)
   );

   wire logic       start_mem  = is_copy || is_indir || is_rel;
   wire logic [PTR_WIDTH-1:0] next_addr = is_copy ? copy_addr : eff_addr;
   wire logic       read_zero  = (mem_rdata == 8'h00);

   // sequencing of memory-based moves
   always_ff @(posedge mclk) begin
      if (reset) begin
         state     <= st_idle;
         busy      <= 1'b0;
         done      <= 1'b0;
         mem_rd_en <= 1'b0;
         mem_wr_en <= 1'b0;
         dest_file <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            st_idle: begin
               if (start_mem) begin
                  state     <= st_read;
                  busy      <= 1'b1;
                  mem_rd_en <= 1'b1;
                  dest_file <= is_copy && copy_dest;
               end else if (is_lit) begin
                  done <= 1'b1;
               end
            end
            st_read: begin
               mem_rd_en <= 1'b0;
               state     <= st_capture;
            end
            st_capture: begin
               if (dest_file) begin
                  mem_wr_en <= 1'b1;
                  state     <= st_write;
               end else begin
                  busy  <= 1'b0;
                  done  <= 1'b1;
                  state <= st_idle;
               end
            end
            st_write: begin
               mem_wr_en <= 1'b0;
               busy      <= 1'b0;
               done      <= 1'b1;
               state     <= st_idle;
            end
            default: begin
               state     <= st_idle;
               busy      <= 1'b0;
               mem_rd_en <= 1'b0;
               mem_wr_en <= 1'b0;
            end
         endcase
      end
   end

   // address and write data
   always_ff @(posedge mclk) begin
      if (reset) begin
         mem_addr  <= `POINTER_RESET;
         mem_wdata <= 8'h00;
      end else begin
         if (start_mem)
            mem_addr <= next_addr;
         if (state == st_capture)
            mem_wdata <= mem_rdata;
      end
   end

   // working register and zero flag
   always_ff @(posedge mclk) begin
      if (reset) begin
         working_reg <= `WORK_RESET;
         zero_flag   <= 1'b0;
      end else if (is_work) begin
         working_reg <= work_k;
      end else if (state == st_capture) begin
         // flag follows the moved byte whichever way it goes
         zero_flag <= read_zero;
         if (!dest_file)
            working_reg <= mem_rdata;
      end
   end

   // literal targets, flags untouched
   always_ff @(posedge mclk) begin
      if (reset) begin
         bank_select_register       <= `BANK_RESET;
         program_counter_high_latch <= `LATCH_RESET;
      end else begin
         if (is_bank)
            bank_select_register <= bank_k;
         if (is_latch)
            program_counter_high_latch <= latch_k;
      end
   end

   // pointer update at issue; final value does not depend on the transfer
   always_ff @(posedge mclk) begin
      if (reset) begin
         pointer_register0 <= `POINTER_RESET;
         pointer_register1 <= `POINTER_RESET;
      end else if ((is_indir || is_rel) && !ptr_sel) begin
         pointer_register0 <= next_ptr;
      end else if ((is_indir || is_rel) && ptr_sel) begin
         pointer_register1 <= next_ptr;
      end
   end
endmodule // data_move_instruction_unit
`default_nettype wire

// file: testbench/data_move_asserts.sv
// assertions for the data-move instruction unit
`timescale 1ns/1ps
`default_nettype none
`include "data_move_defs.svh"
module data_move_asserts
   import data_move_pkg::*;
#(parameter int PTR_WIDTH = 16) (
   input wire logic                      mclk,
   input wire logic                      reset,
   input wire logic                      instr_valid,
   input wire logic [`INSTR_WIDTH-1:0]   instr_word,
   input wire logic                      busy,
   input wire logic                      done,
   input wire logic [PTR_WIDTH-1:0]      mem_addr,
   input wire logic                      mem_rd_en,
   input wire logic                      mem_wr_en,
   input wire logic [7:0]                mem_wdata,
   input wire logic [7:0]                working_reg,
   input wire logic                      zero_flag,
   input wire logic [4:0]                bank_select_register,
   input wire logic [6:0]                program_counter_high_latch,
   input wire logic [PTR_WIDTH-1:0]      pointer_register0
);
   wire logic [2:0] cls  = instr_word[13:11];
   wire logic       take = instr_valid && !busy;
   wire logic       lit  = cls inside {`CLASS_BANK, `CLASS_LATCH, `CLASS_WORK};
   wire logic       p0op = take && cls == `CLASS_INDIR && !instr_word[7];
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence read_s; mem_rd_en ##1 !mem_rd_en ##1 done; endsequence
   sequence wb_s; mem_rd_en ##2 (mem_wr_en && zero_flag == (mem_wdata == 8'h00)) ##1 done; endsequence
   literal_done_a: assert property (take && lit |=> done && !busy && $stable(zero_flag))
      else $error("literal op slow or touched zero flag");
   bank_load_a: assert property (take && cls == `CLASS_BANK |=> bank_select_register == {1'b0, $past(instr_word[3:0])})
      else $error("bank select value wrong");
   latch_load_a: assert property (take && cls == `CLASS_LATCH |=> program_counter_high_latch == $past(instr_word[6:0]))
      else $error("high latch value wrong");
   work_load_a: assert property (take && cls == `CLASS_WORK |=> working_reg == $past(instr_word[7:0]))
      else $error("working literal value wrong");
   read_path_a: assert property (take && (cls inside {`CLASS_INDIR, `CLASS_REL} || cls == `CLASS_COPY && !instr_word[10])
      |=> read_s ##0 (!busy && zero_flag == (working_reg == 8'h00))) else $error("read move wrong");
   write_back_a: assert property (take && cls == `CLASS_COPY && instr_word[10] |=> wb_s)
      else $error("write back sequence wrong");
   ptr_step_a: assert property (p0op |=> pointer_register0 ==
      PTR_WIDTH'($past(pointer_register0) + ($past(instr_word[0]) ? -1 : 1)))
      else $error("pointer step wrong");
   ptr_addr_a: assert property (p0op |=> mem_addr == ($past(instr_word[1]) ? $past(pointer_register0) : pointer_register0))
      else $error("pre or post address wrong");
   rel_offset_a: assert property (take && cls == `CLASS_REL && !instr_word[6] |=> $stable(pointer_register0)
      && mem_addr == pointer_register0 + PTR_WIDTH'($signed($past(instr_word[5:0])))) else $error("offset wrong");
   port_redirect_a: assert property (take && cls == `CLASS_COPY && instr_word[6:0] == 7'h00
      |=> $stable(pointer_register0) && mem_addr == pointer_register0) else $error("redirect wrong");
endmodule // data_move_asserts
bind data_move_instruction_unit data_move_asserts #(.PTR_WIDTH(PTR_WIDTH)) chk_u (.mclk, .reset, .instr_valid,
   .instr_word, .busy, .done, .mem_addr, .mem_rd_en, .mem_wr_en, .mem_wdata, .working_reg, .zero_flag,
   .bank_select_register, .program_counter_high_latch, .pointer_register0);
`default_nettype wire

// file: testbench/data_move_instruction_unit_test.sv
// self-checking bench for the data-move instruction unit
`timescale 1ns/1ps
`default_nettype none
module data_move_instruction_unit_test;
   import data_move_pkg::*;
   typedef struct {logic [15:0] a; logic [7:0] w, d; logic z; logic [4:0] b; logic [6:0] l; logic [15:0] p0, p1;} expect_t;
   logic             mclk = 0, reset = 1, instr_valid = 0;
   logic [13:0]      instr_word = '0;
   logic [7:0]       mem_rdata = '0, w = 0;
   logic             z = 0;
   logic [4:0]       b = 0;
   logic [6:0]       l = 0;
   logic [15:0]      p[2] = '{0, 0};
   wire logic        busy, done, mem_rd_en, mem_wr_en, zero_flag;
   wire logic [15:0] mem_addr, pointer_register0, pointer_register1;
   wire logic [7:0]  mem_wdata, working_reg;
   wire logic [4:0]  bank_select_register;
   wire logic [6:0]  program_counter_high_latch;
   expect_t          q[$], m;
   int               n_fail = 0, tests_run = 0;
   data_move_instruction_unit dut_u (.mclk, .reset, .instr_valid, .instr_word, .mem_rdata, .busy, .done, .mem_addr,
      .mem_rd_en, .mem_wr_en, .mem_wdata, .working_reg, .zero_flag, .bank_select_register,
      .program_counter_high_latch, .pointer_register0, .pointer_register1);
   initial forever #5 mclk = ~mclk;
   task automatic chk(input logic [15:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // model the op, note the result, then present it; literals leave valid up for back-to-back issue
   task automatic run(input logic [13:0] wd, input logic [7:0] rd);
      logic [2:0] c;
      logic       n;
      logic [15:0] a;
      c = wd[13:11];
      n = (c == 3'h2) ? wd[7] : wd[6];
      a = p[n];
      case (c)
         3'h1: a = (wd[6:1] == 6'h0) ? p[wd[0]] : 16'({b, wd[6:0]});
         3'h2: begin
            p[n] = wd[0] ? p[n] - 1 : p[n] + 1;
            if (!wd[1]) a = p[n];
         end
         3'h3: a = a + 16'($signed(wd[5:0]));
         3'h4: b = {1'b0, wd[3:0]};
         3'h5: l = wd[6:0];
         3'h6: w = wd[7:0];
         default: ;
      endcase
      if (c inside {3'h1, 3'h2, 3'h3}) begin
         z = (rd == 8'h00);
         if (!(c == 3'h1 && wd[10])) w = rd;
      end
      if (c inside {[3'h1:3'h6]}) q.push_back('{a, w, rd, z, b, l, p[0], p[1]});
      instr_word = wd;
      instr_valid = 1;
      @(negedge mclk);
      if (c inside {3'h1, 3'h2, 3'h3}) begin
         instr_valid = 0;
         mem_rdata = rd;
         for (int i = 0; i < 8 && busy; i++) @(negedge mclk);
         mem_rdata = ~rd; // stale data must not be mistaken for a fresh read
      end
   endtask
   always @(posedge mclk) begin
      #1;
      if (mem_rd_en) chk(mem_addr, q[0].a);
      if (mem_wr_en) chk({mem_addr[7:0], mem_wdata}, {q[0].a[7:0], q[0].d});
      if (done) begin
         m = q.pop_front(); // empty queue gives unknowns, so a refused op that finishes is caught
         chk({working_reg, 7'h0, zero_flag}, {m.w, 7'h0, m.z});
         chk({bank_select_register, 2'h0, program_counter_high_latch}, {m.b, 2'h0, m.l});
         chk(pointer_register0, m.p0);
         chk(pointer_register1, m.p1);
      end
   end
   initial begin
      #20000;
      n_fail++;
      end_of_test;
   end
   initial begin
      void'($urandom(70216));
      repeat (20) @(negedge mclk);
      reset = 0;
      for (int k = 0; k < 8; k++) run({3'h2, 3'h0, k[2], 5'h0, k[1:0] ^ 2'h1}, 8'(k * 37));
      run({3'h3, 4'h0, 1'b0, 6'h20}, 8'h5a);
      run({3'h3, 4'h0, 1'b1, 6'h1f}, 8'h00);
      run({3'h1, 1'b0, 3'h0, 7'h00}, 8'($urandom));
      run({3'h1, 1'b1, 3'h0, 7'h01}, 8'h00);
      for (int k = 0; k < 16; k++) run({3'h4, 7'h0, k[3:0]}, 8'h00);
      run({3'h1, 1'b1, 3'h0, 7'h7f}, 8'h00);
      run({3'h5, 4'h0, 7'h7f}, 8'h00);
      run({3'h6, 3'h0, 8'hff}, 8'h00);
      run({3'h6, 3'h0, 8'h00}, 8'h00);
      run({3'h0, 11'h7ff}, 8'h00);
      run({3'h7, 11'h7ff}, 8'h00);
      repeat (80) run(14'($urandom_range(14'h37ff, 14'h0800)), 8'($urandom));
      instr_valid = 0;
      repeat (6) @(negedge mclk);
      end_of_test;
   end
endmodule // data_move_instruction_unit_test
`default_nettype wire
